// File: design/ifcnt_pkg.sv
package ifcnt_pkg;
	// ----------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------
	localparam logic [7:0] IDX_MODE = 8'hf4;
	localparam logic [7:0] IDX_HIGH = 8'hf5;
	localparam logic [7:0] IDX_MID = 8'hf6;
	localparam logic [7:0] IDX_LOW = 8'hf7;
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
	localparam logic [11:0] ADDR_HIGH = {2'h0, IDX_HIGH, 2'h0};
	localparam logic [11:0] ADDR_MID = {2'h0, IDX_MID, 2'h0};
	localparam logic [11:0] ADDR_LOW = {2'h0, IDX_LOW, 2'h0};

	// ----------------------------------------
	// Mode register fields, plus the overflow bit of the high register
	// ----------------------------------------
	localparam int BIT_JUDGE = 7;
	localparam int BIT_START = 6;
	localparam int BIT_CLEAR = 5;
	localparam int BIT_GATE_HI = 3;
	localparam int BIT_GATE_LO = 2;
	localparam int BIT_IN_HI = 1;
	localparam int BIT_IN_LO = 0;
	localparam int BIT_OVF = 3;
	localparam logic [1:0] GATE_8MS = 2'h0;
	localparam logic [1:0] GATE_32MS = 2'h1;
	localparam logic [1:0] GATE_128MS = 2'h2;
	localparam logic [1:0] GATE_SOFT = 2'h3;
	localparam logic [1:0] IN_FM = 2'h2;
	localparam logic [1:0] IN_AM = 2'h3;

	// ----------------------------------------
	// Reset values and widths
	// ----------------------------------------
	localparam int COUNT_W = 19;
	localparam logic [18:0] COUNT_RESET = 19'h00000;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_KHZ = 40000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = (TICK_US * CLK_KHZ) / 1000;
	localparam logic [7:0] GATE_8_MS = 8'h08;
	localparam logic [7:0] GATE_32_MS = 8'h20;
	localparam logic [7:0] GATE_128_MS = 8'h80;

	// Gate sequencer states, one-hot
	typedef enum logic [3:0] {
		IFCNT_IDLE = 4'h1,
		IFCNT_ARMED = 4'h2,
		IFCNT_OPEN = 4'h4,
		IFCNT_SOFT = 4'h8
	} ifcnt_state_t;
endpackage

// File: design/ifcnt_top.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module ifcnt_top #(
	parameter int TICK_CYCLES = ifcnt_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fm_if_input,
	input wire logic am_if_input,
	output logic fm_select,
	output logic am_select,
	output logic gate_open
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0] mode;
	logic judge;
	logic ovf;
	logic [18:0] count;
	logic [31:0] tick_cnt;
	logic tick;
	logic [7:0] gate_ticks;
	ifcnt_pkg::ifcnt_state_t state;
	ifcnt_pkg::ifcnt_state_t next_state;
	logic fm_s1;
	logic fm_s2;
	logic fm_s3;
	logic am_s1;
	logic am_s2;
	logic am_s3;
	logic [1:0] prescale;
	logic clear_req;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire hit_mode = (paddr == ifcnt_pkg::ADDR_MODE);
	wire hit_high = (paddr == ifcnt_pkg::ADDR_HIGH);
	wire hit_mid = (paddr == ifcnt_pkg::ADDR_MID);
	wire hit_low = (paddr == ifcnt_pkg::ADDR_LOW);
	wire hit_any = hit_mode | hit_high | hit_mid | hit_low;
	wire wr_mode = access & pwrite & hit_mode & pstrb[0];
	wire rd_mode = access & ~pwrite & hit_mode;
	wire [7:0] wbyte = pwdata[7:0];
	wire start_wr = wr_mode & wbyte[ifcnt_pkg::BIT_START];
	wire clear_wr = wr_mode & wbyte[ifcnt_pkg::BIT_CLEAR];

	// Fields of the mode register
	wire [1:0] gate_sel = mode[ifcnt_pkg::BIT_GATE_HI:ifcnt_pkg::BIT_GATE_LO];
	wire [1:0] in_sel = mode[ifcnt_pkg::BIT_IN_HI:ifcnt_pkg::BIT_IN_LO];
	wire start_bit = mode[ifcnt_pkg::BIT_START];
	wire soft_mode = (gate_sel == ifcnt_pkg::GATE_SOFT);
	// Stop and field writes act at their own edge, so no extra count cycle
	wire start_eff = wr_mode ? wbyte[ifcnt_pkg::BIT_START] :
		start_bit;
	wire soft_eff = wr_mode ? (wbyte[3:2] == ifcnt_pkg::GATE_SOFT) :
		soft_mode;

	// ----------------------------------------
	// Read data view
	// ----------------------------------------
	// Mode: judge on top, clear bit and reserved bit read zero
	wire [7:0] mode_view = {judge, start_bit, 2'h0, mode[3:0]};
	// High register: reserved nibble zero, overflow, top count bits
	wire [7:0] high_view = {4'h0, ovf, count[18:16]};
	wire [7:0] mid_view = count[15:8];
	wire [7:0] low_view = count[7:0];
	wire [7:0] rd_byte = hit_mode ? mode_view :
		hit_high ? high_view :
		hit_mid ? mid_view :
		hit_low ? low_view : 8'h00;

	// Zero-wait slave: data is latched in the setup cycle
	assign pready = 1'b1;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
			pslverr <= ~hit_any;
		end
	end

	// ----------------------------------------
	// Input selection and synchronisers
	// ----------------------------------------
	// Pins are asynchronous to pclk; third stage feeds edge detect
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fm_s1 <= 1'b0;
			fm_s2 <= 1'b0;
			fm_s3 <= 1'b0;
			am_s1 <= 1'b0;
			am_s2 <= 1'b0;
			am_s3 <= 1'b0;
		end
		else
		begin
			fm_s1 <= fm_if_input;
			fm_s2 <= fm_s1;
			fm_s3 <= fm_s2;
			am_s1 <= am_if_input;
			am_s2 <= am_s1;
			am_s3 <= am_s2;
		end
	end

	// Only rising edges count; level at gate close has no effect
	wire fm_rise = fm_s2 & ~fm_s3;
	wire am_rise = am_s2 & ~am_s3;
	assign fm_select = (in_sel == ifcnt_pkg::IN_FM);
	assign am_select = (in_sel == ifcnt_pkg::IN_AM);

	// FM path is divided by four; prescaler restarts on clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prescale <= 2'h0;
		else if (clear_req)
			prescale <= 2'h0;
		else if (gate_open && fm_select && fm_rise)
			prescale <= prescale + 2'h1;
	end

	wire fm_evt = fm_select & fm_rise & (prescale == 2'h3);
	wire am_evt = am_select & am_rise;
	// A disabled input (0x) produces no events at all
	wire cnt_evt = gate_open & (fm_evt | am_evt);

	// ----------------------------------------
	// 1 kHz timebase
	// ----------------------------------------
	// Free-running so the first tick after start lands anywhere
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt <= 32'h00000000;
		else if (tick)
			tick_cnt <= 32'h00000000;
		else
			tick_cnt <= tick_cnt + 32'h00000001;
	end

	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

	// ----------------------------------------
	// Gate sequencer
	// ----------------------------------------
	// Length of the fixed gate in ticks
	wire [7:0] gate_len = (gate_sel == ifcnt_pkg::GATE_8MS) ?
		ifcnt_pkg::GATE_8_MS :
		(gate_sel == ifcnt_pkg::GATE_32MS) ?
		ifcnt_pkg::GATE_32_MS : ifcnt_pkg::GATE_128_MS;
	wire gate_done = tick & (gate_ticks == gate_len - 8'h01);

	always_comb
	begin
		next_state = state;
		case (state)
			ifcnt_pkg::IFCNT_IDLE:
			begin
				if (start_wr)
				begin
					if (wbyte[3:2] == ifcnt_pkg::GATE_SOFT)
						next_state = ifcnt_pkg::IFCNT_SOFT;
					else
						next_state = ifcnt_pkg::IFCNT_ARMED;
				end
			end
			ifcnt_pkg::IFCNT_ARMED:
			begin
				if (!start_eff)
					next_state = ifcnt_pkg::IFCNT_IDLE;
				else if (tick)
					next_state = ifcnt_pkg::IFCNT_OPEN;
			end
			ifcnt_pkg::IFCNT_OPEN:
			begin
				if (!start_eff || gate_done)
					next_state = ifcnt_pkg::IFCNT_IDLE;
			end
			ifcnt_pkg::IFCNT_SOFT:
			begin
				if (!start_eff || !soft_eff)
					next_state = ifcnt_pkg::IFCNT_IDLE;
			end
			default:
				next_state = ifcnt_pkg::IFCNT_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ifcnt_pkg::IFCNT_IDLE;
		else
			state <= next_state;
	end

	// Ticks elapsed inside an open fixed gate
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gate_ticks <= 8'h00;
		else if (state != ifcnt_pkg::IFCNT_OPEN)
			gate_ticks <= 8'h00;
		else if (tick)
			gate_ticks <= gate_ticks + 8'h01;
	end

	// Soft gate follows the start bit with no tick alignment
	assign gate_open = (state == ifcnt_pkg::IFCNT_OPEN) ||
		(state == ifcnt_pkg::IFCNT_SOFT);

	// ----------------------------------------
	// Mode register
	// ----------------------------------------
	// Start clears itself at fixed-gate expiry; soft mode keeps it
	wire fixed_end = (state == ifcnt_pkg::IFCNT_OPEN) && gate_done;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode <= ifcnt_pkg::MODE_RESET;
		else if (wr_mode)
			mode <= {1'b0, wbyte[6], 2'h0, wbyte[3:0]};
		else if (fixed_end)
			mode[ifcnt_pkg::BIT_START] <= 1'b0;
	end

	// Clear bit is a one-cycle command, it never stores
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clear_req <= 1'b0;
		else
			clear_req <= clear_wr;
	end

	// Judge: set on start, cleared at expiry or by a mode read.
	// Set wins over a read in the same cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			judge <= 1'b0;
		else if (start_wr)
			judge <= 1'b1;
		else if (fixed_end)
			judge <= 1'b0;
		else if (rd_mode)
			judge <= 1'b0;
	end

	// ----------------------------------------
	// Counter and overflow
	// ----------------------------------------
	// Wraps at full range; hold value otherwise until cleared
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= ifcnt_pkg::COUNT_RESET;
		else if (clear_req)
			count <= ifcnt_pkg::COUNT_RESET;
		else if (cnt_evt)
			count <= count + 19'h00001;
	end

	wire wrap = cnt_evt & (count == 19'h7ffff);

	// Overflow sticks; a wrap in the clearing cycle still sets it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ovf <= 1'b0;
		else if (wrap)
			ovf <= 1'b1;
		else if (clear_req)
			ovf <= 1'b0;
	end

	// Writes to the count registers fall through untouched
	wire wr_data_ignored = access & pwrite &
		(hit_high | hit_mid | hit_low);
	logic unused_ok;
	assign unused_ok = wr_data_ignored & pwdata[31] & pstrb[3];
endmodule

// File: test/if_frequency_counter_bench.sv
`timescale 1ns/10ps
module if_frequency_counter_bench;
	localparam int TICK = 10;
	localparam logic [11:0] A_MODE = ifcnt_pkg::ADDR_MODE;
	localparam logic [11:0] A_LOW = ifcnt_pkg::ADDR_LOW;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, kick = 1'b0, pready, pslverr, wave, busy, gate_open;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [7:0] npul = 8'h00;
	int bad_count = 0, n_tests = 0;
	always #12.5 pclk = ~pclk;
	ifcnt_top #(.TICK_CYCLES(TICK)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fm_if_input(wave), .am_if_input(wave),
		.fm_select(), .am_select(), .gate_open(gate_open));
	ifcnt_source src (.pclk(pclk), .kick(kick), .pulses(npul),
		.wave(wave), .busy(busy));
	task automatic check(input string nm, input logic [31:0] s, x);
		n_tests++;
		if (s !== x)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	// APB cycle, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never re-drives in this step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input string nm);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(nm, q, x);
	endtask
	task automatic send(input logic [7:0] n);
		kick <= 1'b1;
		npul <= n;
		@(posedge pclk);
		kick <= 1'b0;
		@(posedge pclk);
		while (busy)
			@(posedge pclk);
		repeat (4) @(posedge pclk);
	endtask
	task automatic wait_gate(input logic lvl);
		int i = 0;
		while (gate_open !== lvl && i < 2000)
		begin
			@(posedge pclk);
			i++;
		end
		check("gate_open", {31'h0, gate_open}, {31'h0, lvl});
	endtask
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		for (int i = 0; i < 4; i++)
			rd(A_MODE + 12'(4 * i), 32'h0, "reset value");
		apb(1'b0, 12'h000, 32'h0, q, e);
		check("unmapped error", {31'h0, e}, 32'h1);
		$display("test reset done");
	endtask
	task automatic t_soft();
		wr(A_MODE, 32'h0f);
		repeat (4) @(posedge pclk);
		wr(A_MODE, 32'h2f);
		wr(A_MODE, 32'h4f);
		send(8'h05);
		wr(A_MODE, 32'h0f);
		rd(A_LOW, 32'h05, "am soft count");
		rd(A_MODE, 32'h8f, "judge held");
		rd(A_MODE, 32'h0f, "judge read clear");
		send(8'h03);
		rd(A_LOW, 32'h05, "held count");
		wr(A_MODE, 32'h2c);
		wr(A_MODE, 32'h4c);
		send(8'h04);
		wr(A_MODE, 32'h0c);
		rd(A_LOW, 32'h00, "input off");
		$display("test soft done");
	endtask
	task automatic t_fixed();
		logic [31:0] m;
		for (int g = 0; g < 3; g++)
		begin
			m = {28'h0, 2'(g), 2'h2};
			wr(A_MODE, m);
			wr(A_MODE, m | 32'h20);
			wr(A_MODE, m | 32'h40);
			wait_gate(1'b1);
			send(8'h10);
			wait_gate(1'b0);
			rd(A_LOW, 32'h04, "fm fixed count");
			rd(A_MODE, m, "judge expired");
		end
		wr(A_LOW, 32'hff);
		rd(A_LOW, 32'h04, "read only");
		wr(A_MODE, 32'h22);
		rd(A_LOW, 32'h00, "cleared");
		$display("test fixed done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_soft();
		t_fixed();
		end_of_test();
	end
	// Watchdog: all gates together need well under 4000 cycles
	initial
	begin
		#500000;
		bad_count++;
		end_of_test();
	end
endmodule

// File: test/ifcnt_assertions.sv
`timescale 1ns/10ps
module ifcnt_assertions #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic fm_select,
	input wire logic am_select,
	input wire logic gate_open
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Mode write as the design takes it
	wire mode_wr = psel && penable && pwrite && pstrb[0]
		&& paddr == ifcnt_pkg::ADDR_MODE;
	logic [1:0] gsel;
	logic [19:0] run;
	wire [19:0] len = 20'(TICK_CYCLES) <<
		(gsel == 2'h0 ? 3 : gsel == 2'h1 ? 5 : 7);
	sequence soft_go;
		mode_wr && pwdata[6] && pwdata[3:2] == 2'h3;
	endsequence
	sequence fixed_go;
		mode_wr && pwdata[6] && pwdata[3:2] != 2'h3 && !gate_open;
	endsequence
	// Stop writes count as soft, so an abort never trips the length check
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gsel <= 2'h0;
			run <= 20'h00000;
		end
		else
		begin
			if (mode_wr)
				gsel <= pwdata[6] ? pwdata[3:2] : 2'h3;
			run <= gate_open ? run + 20'h00001 : 20'h00000;
		end
	end
	fm_pick_a: assert property (
		mode_wr && pwdata[1:0] == 2'h2 |=> fm_select && !am_select)
		else $error("fm select wrong");
	am_pick_a: assert property (
		mode_wr && pwdata[1:0] == 2'h3 |=> am_select && !fm_select)
		else $error("am select wrong");
	input_off_a: assert property (
		mode_wr && !pwdata[1] |=> !am_select && !fm_select)
		else $error("inputs not off");
	soft_open_a: assert property (soft_go |=> gate_open)
		else $error("soft gate late");
	stop_close_a: assert property (
		mode_wr && !pwdata[6] |=> !gate_open)
		else $error("gate open after stop");
	tick_wait_a: assert property (fixed_go |=> !gate_open)
		else $error("fixed gate opened without tick");
	gate_len_a: assert property (
		$fell(gate_open) && gsel != 2'h3 |-> run == len)
		else $error("fixed gate length wrong");
	high_res_a: assert property (
		psel && !penable && !pwrite && paddr == ifcnt_pkg::ADDR_HIGH
		|=> prdata[31:4] == 28'h0)
		else $error("high register reserved bits set");
endmodule
bind ifcnt_top ifcnt_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .fm_select(fm_select), .am_select(am_select),
	.gate_open(gate_open));

// File: test/ifcnt_source.sv
`timescale 1ns/10ps
module ifcnt_source (
	input wire logic pclk,
	input wire logic kick,
	input wire logic [7:0] pulses,
	output logic wave,
	output logic busy
);
	logic [7:0] left = 8'h00;
	logic [1:0] ph = 2'h0;
	// Two high, two low: the fastest the pin synchroniser still sees
	always @(posedge pclk)
	begin
		if (kick)
		begin
			left <= pulses;
			ph <= 2'h0;
		end
		else if (left != 8'h00)
		begin
			ph <= ph + 2'h1;
			if (ph == 2'h3)
				left <= left - 8'h01;
		end
	end
	// Line rests low between bursts
	assign busy = left != 8'h00;
	assign wave = busy && ph < 2'h2;
endmodule
